// ---- rso_top.sv ----
// register-subtract instruction unit with APB register access and interrupt
`timescale 1ns/10ps
`include "rso_consts.svh"
`default_nettype none

module rso_top (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  output logic             BRANCH,
  output logic             OVERFLOW
);
  logic [31:0]         rf [0:`RSO_RF_DEPTH-1];
  logic [31:0]         fm [0:`RSO_FM_DEPTH-1];

  rso_pkg::rso_state_t state, next_state;
  logic [31:0]         instr, next_instr;
  logic [5:0]          rf_index, next_rf_index;
  logic [3:0]          fm_link, next_fm_link;
  logic [31:0]         result, next_result;
  logic                always_seen, next_always_seen;
  logic                rst_meta_n, rst_sync_n;
  logic [`RSO_EV_W-1:0] irq_status, next_irq_status;
  logic [`RSO_EV_W-1:0] irq_enable, next_irq_enable;
  logic [31:0]         next_prdata;
  logic                next_pready, next_pslverr, next_irq, next_branch, next_overflow;
  logic                rf_we, fm_we;
  logic [5:0]          rf_wa;
  logic [31:0]         rf_wd;
  logic [3:0]          fm_wa;
  logic [31:0]         fm_wd;

  logic [31:0]         alu_result;
  logic                alu_ovf, alu_branch;
  logic                setup, access_wr;
  logic [`RSO_EV_W-1:0] events, clears;

  rso_sub_core u_core (
    .opa                 (rf[instr[`RSO_RSA_HI:`RSO_RSA_LO]]),
    .opb                 (rf[{1'b0, instr[`RSO_RSB_HI:`RSO_RSB_LO]}]),
    .modulo_select_field (instr[`RSO_MOD_HI:`RSO_MOD_LO]),
    .cond                (rso_pkg::rso_cond_t'(instr[`RSO_COND_HI:`RSO_COND_LO])),
    .ovf_prev            (OVERFLOW),
    .result              (alu_result),
    .ovf_next            (alu_ovf),
    .take_branch         (alu_branch)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `RSO_OFF_IRQ_ENABLE);
  endfunction

  // bus slave: read data and ready are prepared in the setup cycle
  always_comb begin
    setup        = PSEL && !PENABLE && !PREADY;
    access_wr    = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    next_pready  = setup;
    next_pslverr = setup && !mapped(PADDR);
    next_prdata  = `RSO_RST_WORD;
    if (setup && !PWRITE) begin
      unique case (PADDR)
        `RSO_OFF_INSTR:      next_prdata = instr;
        `RSO_OFF_RF_INDEX:   next_prdata = {26'h0000000, rf_index};
        `RSO_OFF_RF_DATA:    next_prdata = rf[rf_index];
        `RSO_OFF_FLAGS:      next_prdata = {28'h0000000, (state == rso_pkg::ST_EXEC),
                                            always_seen, BRANCH, OVERFLOW};
        `RSO_OFF_RESULT:     next_prdata = result;
        `RSO_OFF_FM_LINK:    next_prdata = {28'h0000000, fm_link};
        `RSO_OFF_FM_DATA:    next_prdata = fm[fm_link];
        `RSO_OFF_IRQ_STATUS: next_prdata = {28'h0000000, irq_status};
        `RSO_OFF_IRQ_ENABLE: next_prdata = {28'h0000000, irq_enable};
        default:             next_prdata = `RSO_RST_WORD;
      endcase
    end
  end

  // execution and register state
  always_comb begin
    next_state      = rso_pkg::ST_IDLE;
    next_instr      = instr;
    next_rf_index   = rf_index;
    next_fm_link    = fm_link;
    next_result     = result;
    next_always_seen = always_seen;
    next_irq_enable = irq_enable;
    next_branch     = 1'b0;
    next_overflow   = OVERFLOW;
    events          = '0;
    clears          = '0;
    rf_we           = 1'b0;
    rf_wa           = rf_index;
    rf_wd           = PWDATA;
    fm_we           = 1'b0;
    fm_wa           = fm_link;
    fm_wd           = PWDATA;

    if (access_wr) begin
      unique case (PADDR)
        `RSO_OFF_INSTR: begin
          next_instr = PWDATA;
          if (PWDATA[`RSO_OPC_HI:`RSO_OPC_LO] == `RSO_OPCODE) begin
            next_state = rso_pkg::ST_EXEC;
          end else begin
            events[`RSO_EV_ILLEGAL] = 1'b1;
          end
        end
        `RSO_OFF_RF_INDEX:   next_rf_index = PWDATA[5:0];
        `RSO_OFF_RF_DATA:    rf_we = 1'b1;
        `RSO_OFF_FM_LINK:    next_fm_link = PWDATA[3:0];
        `RSO_OFF_FM_DATA:    fm_we = 1'b1;
        `RSO_OFF_IRQ_CLEAR:  clears = PWDATA[`RSO_EV_W-1:0];
        `RSO_OFF_IRQ_ENABLE: next_irq_enable = PWDATA[`RSO_EV_W-1:0];
        default: begin
        end
      endcase
    end

    // a bus write never lands in the execute cycle, so array ports do not collide
    if (state == rso_pkg::ST_EXEC) begin
      rf_we         = 1'b1;
      rf_wa         = instr[`RSO_RD_HI:`RSO_RD_LO];
      rf_wd         = alu_result;
      next_result   = alu_result;
      next_overflow = alu_ovf;
      next_branch   = alu_branch;
      next_always_seen = instr[`RSO_ALWEX_BIT];
      if (instr[`RSO_MEMUPD_BIT]) begin
        fm_we = 1'b1;
        fm_wd = alu_result;
      end
      events[`RSO_EV_DONE]   = 1'b1;
      events[`RSO_EV_OVF]    = alu_ovf && !OVERFLOW;
      events[`RSO_EV_BRANCH] = alu_branch;
    end

    // a new event beats a clear in the same cycle
    next_irq_status = (irq_status & ~clears) | events;
    next_irq        = |(next_irq_status & next_irq_enable);
  end

  // the pin reset drops every flop outside the rf and fm arrays at once but is let go only on a clock edge,
  // so no flop sees its release inside a setup window; costs two cycles after release
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  always_ff @(posedge MCLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      PRDATA  <= `RSO_RST_WORD;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  always_ff @(posedge MCLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state       <= rso_pkg::ST_IDLE;
      instr       <= `RSO_RST_WORD;
      rf_index    <= 6'h00;
      fm_link     <= 4'h0;
      result      <= `RSO_RST_WORD;
      always_seen <= 1'b0;
      BRANCH      <= 1'b0;
      OVERFLOW    <= 1'b0;
    end else begin
      state       <= next_state;
      instr       <= next_instr;
      rf_index    <= next_rf_index;
      fm_link     <= next_fm_link;
      result      <= next_result;
      always_seen <= next_always_seen;
      BRANCH      <= next_branch;
      OVERFLOW    <= next_overflow;
    end
  end

  always_ff @(posedge MCLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_status <= '0;
      irq_enable <= '0;
      IRQ        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      IRQ        <= next_irq;
    end
  end

  // arrays are not reset: contents are undefined until software loads them
  always_ff @(posedge MCLK) begin
    if (rf_we) begin
      rf[rf_wa] <= rf_wd;
    end
    if (fm_we) begin
      fm[fm_wa] <= fm_wd;
    end
  end
endmodule

`default_nettype wire

// ---- rso_consts.svh ----
// offsets, field positions, reset values and counts of the register-subtract unit
`ifndef RSO_CONSTS_SVH
`define RSO_CONSTS_SVH

`define RSO_OFF_INSTR      8'h00
`define RSO_OFF_RF_INDEX   8'h04
`define RSO_OFF_RF_DATA    8'h08
`define RSO_OFF_FLAGS      8'h0C
`define RSO_OFF_RESULT     8'h10
`define RSO_OFF_FM_LINK    8'h14
`define RSO_OFF_FM_DATA    8'h18
`define RSO_OFF_IRQ_STATUS 8'h1C
`define RSO_OFF_IRQ_CLEAR  8'h20
`define RSO_OFF_IRQ_ENABLE 8'h24

`define RSO_OPCODE         6'h22
`define RSO_OPC_HI         31
`define RSO_OPC_LO         26
`define RSO_RD_HI          25
`define RSO_RD_LO          20
`define RSO_MEMUPD_BIT     19
`define RSO_COND_HI        18
`define RSO_COND_LO        16
`define RSO_RSA_HI         15
`define RSO_RSA_LO         10
`define RSO_MOD_HI         9
`define RSO_MOD_LO         6
`define RSO_ALWEX_BIT      5
`define RSO_RSB_HI         4
`define RSO_RSB_LO         0

`define RSO_RF_DEPTH       64
`define RSO_FM_DEPTH       16
`define RSO_MOD_FULL       4'h8

`define RSO_EV_DONE        0
`define RSO_EV_OVF         1
`define RSO_EV_BRANCH      2
`define RSO_EV_ILLEGAL     3
`define RSO_EV_W           4

`define RSO_RST_WORD       32'h00000000
`endif

// ---- rso_pkg.sv ----
// types of the register-subtract unit
package rso_pkg;
  typedef enum logic [2:0] {
    COND_NEVER, COND_ZERO, COND_NONZERO, COND_NEG,
    COND_NONNEG, COND_OVF, COND_POS, COND_ALWAYS
  } rso_cond_t;

  typedef enum logic {ST_IDLE, ST_EXEC} rso_state_t;
endpackage

// ---- rso_sub_core.sv ----
// subtractor datapath: difference, modulo merge, overflow and branch decision
`timescale 1ns/10ps
`include "rso_consts.svh"
`default_nettype none

module rso_sub_core (
  input  wire logic              [31:0] opa,
  input  wire logic              [31:0] opb,
  input  wire logic              [3:0]  modulo_select_field,
  input  wire rso_pkg::rso_cond_t       cond,
  input  wire logic                     ovf_prev,
  output logic                   [31:0] result,
  output logic                          ovf_next,
  output logic                          take_branch
);
  logic [31:0] diff;
  logic [31:0] mask;
  logic        modulo;

  // field value k of 1..7 selects wrap at 2^(4k), 8..15 a full 32-bit wrap; 0 means plain 32-bit arithmetic
  function automatic logic [31:0] mod_mask(input logic [3:0] m);
    logic [5:0] bits;
    bits = {m[3:0], 2'b00};
    if (m == 4'h0 || m >= `RSO_MOD_FULL) begin
      mod_mask = 32'hFFFFFFFF;
    end else begin
      mod_mask = (32'h00000001 << bits) - 32'h00000001;
    end
  endfunction

  always_comb begin
    modulo = (modulo_select_field != 4'h0);
    mask   = mod_mask(modulo_select_field);
    diff   = opa - opb;
    // upper bits of the first source stay put, so a ring pointer keeps its base
    result = (opa & ~mask) | (diff & mask);
    if (modulo) begin
      ovf_next = ovf_prev;
    end else begin
      ovf_next = (opa[31] != opb[31]) && (diff[31] == opb[31]);
    end
    unique case (cond)
      rso_pkg::COND_NEVER:   take_branch = 1'b0;
      rso_pkg::COND_ZERO:    take_branch = (result == 32'h00000000);
      rso_pkg::COND_NONZERO: take_branch = (result != 32'h00000000);
      rso_pkg::COND_NEG:     take_branch = result[31];
      rso_pkg::COND_NONNEG:  take_branch = ~result[31];
      rso_pkg::COND_OVF:     take_branch = ovf_next;
      rso_pkg::COND_POS:     take_branch = ~result[31] && (result != 32'h00000000);
      rso_pkg::COND_ALWAYS:  take_branch = 1'b1;
    endcase
  end
endmodule

`default_nettype wire

// ---- rso_monitor.sv ----
// protocol and datapath checker watching the ports of rso_top
`timescale 1ns/10ps
`default_nettype none
module rso_monitor (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        IRQ,
  input wire logic        BRANCH,
  input wire logic        OVERFLOW
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  logic wr_instr;
  assign wr_instr = PSEL && PENABLE && PWRITE && PADDR == 8'h00;
  property p_ready_next; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_access; PREADY |-> PSEL && PENABLE; endproperty
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  property p_err_ready; PSLVERR |-> PREADY; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_rdata_idle; !PREADY |-> PRDATA == 32'h00000000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_branch_pulse; BRANCH |=> !BRANCH; endproperty
  a_branch_pulse: assert property (p_branch_pulse) else $error("branch longer than one cycle");
  property p_branch_cause; BRANCH |-> $past(wr_instr && PWDATA[31:26] == 6'h22, 2); endproperty
  a_branch_cause: assert property (p_branch_cause) else $error("branch without subtract");
  property p_ovf_cause; $changed(OVERFLOW) |-> $past(wr_instr, 2); endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow moved on its own");
  property p_mod_keep; wr_instr && PWDATA[9:6] != 4'h0 |-> ##2 $stable(OVERFLOW); endproperty
  a_mod_keep: assert property (p_mod_keep) else $error("modulo changed overflow");
  property p_irq_mask;
    PSEL && PENABLE && PWRITE && PADDR == 8'h24 && PWDATA[3:0] == 4'h0 |-> ##2 !IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq high while masked");
endmodule
`default_nettype wire

// ---- tb_register_subtract_alu_op.sv ----
// self-checking bench of the register-subtract unit over apb
`timescale 1ns/10ps
`default_nettype none
module tb_register_subtract_alu_op;
  logic MCLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, BRANCH, OVERFLOW;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, a, b, res, q, dif, msk;
  logic [5:0] ra, rd;
  logic [4:0] rb;
  logic [3:0] md, lk;
  logic [2:0] cnd;
  logic upd, alw, ovf, po, nv, br, e;
  int failures, comparisons, cyc;
  rso_top dut_u (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .BRANCH(BRANCH), .OVERFLOW(OVERFLOW));
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= ad; PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin @(posedge MCLK); n++; end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = PRDATA; e = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 6000) begin failures++; give_verdict(); end
  end
  initial begin
    {PSEL, PENABLE, PWRITE, RESETN, ovf} = 5'h00; PADDR = 8'h00; PWDATA = 32'h00000000;
    void'($urandom(32'h11B6E08B));
    repeat (16) @(posedge MCLK);
    RESETN <= 1'b1;
    // the unit lets go of its internal reset two edges after the pin
    repeat (2) @(posedge MCLK);
    apb(1, 8'h24, 32'h0000000F);
    for (int i = 0; i < 32; i++) begin
      ra = 6'($urandom); rb = 5'($urandom); rd = 6'($urandom); lk = 4'($urandom);
      a = $urandom; b = $urandom; upd = 1'($urandom); alw = 1'($urandom); cnd = 3'(i);
      // every modulo code 1..15 is reached: 1..8 in the first half, 8..15 in the second
      md = i[3] ? 4'(i[4] ? 8 + i % 8 : 1 + i % 8) : 4'h0;
      apb(1, 8'h04, {26'h0, ra}); apb(1, 8'h08, a);
      apb(1, 8'h04, {27'h0, rb}); apb(1, 8'h08, b);
      if ({1'b0, rb} == ra) a = b;
      apb(1, 8'h14, {28'h0, lk});
      apb(1, 8'h00, {6'h22, rd, upd, cnd, ra, md, alw, rb});
      dif = a - b;
      nv = (a[31] != b[31]) && (dif[31] == b[31]);
      // codes 1..7 wrap the low 4k bits and keep the upper bits of the first source
      msk = (md == 4'h0 || md >= 4'h8) ? 32'hFFFFFFFF : (32'h1 << (4 * md)) - 32'h1;
      res = (a & ~msk) | (dif & msk);
      po = ovf;
      if (md == 4'h0) ovf = nv;
      case (cnd)
        3'd0: br = 0; 3'd1: br = res == 0; 3'd2: br = res != 0; 3'd3: br = res[31];
        3'd4: br = !res[31]; 3'd5: br = ovf; 3'd6: br = !res[31] && res != 0; default: br = 1;
      endcase
      // the branch pulse stands only in the cycle after the execute cycle
      @(posedge MCLK);
      @(posedge MCLK);
      chk({31'h0, BRANCH}, {31'h0, br});
      apb(0, 8'h10, 0); chk(q, res);
      apb(0, 8'h0C, 0); chk(q, {28'h0, 1'b0, alw, 1'b0, ovf});
      chk({31'h0, OVERFLOW}, {31'h0, ovf});
      if (upd) begin apb(1, 8'h14, {28'h0, lk}); apb(0, 8'h18, 0); chk(q, res); end
      apb(1, 8'h04, {26'h0, rd}); apb(0, 8'h08, 0); chk(q, res);
      apb(0, 8'h1C, 0); chk(q, {28'h0, 1'b0, br, ovf && !po, 1'b1});
      chk({31'h0, IRQ}, 32'h1);
      apb(1, 8'h20, 32'h0000000F); apb(0, 8'h1C, 0); chk(q, 32'h0);
    end
    // a near-miss opcode must not execute, only flag an illegal write
    apb(1, 8'h00, {6'h23, 26'h3FFFFFF}); apb(0, 8'h1C, 0); chk(q, 32'h8);
    apb(0, 8'h10, 0); chk(q, res);
    chk({31'h0, IRQ}, 32'h1);
    apb(1, 8'h24, 32'h0); apb(0, 8'h1C, 0); chk({31'h0, IRQ}, 32'h0);
    apb(1, 8'h10, $urandom); apb(0, 8'h10, 0); chk(q, res);
    apb(0, 8'h40, 0); chk({e, q[30:0]}, 32'h80000000);
    give_verdict();
  end
endmodule
bind rso_top rso_monitor mon_u (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .BRANCH(BRANCH), .OVERFLOW(OVERFLOW));
`default_nettype wire
